// ===== pdt_pkg.sv
package pdt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 8;
  localparam int IDX_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_OV_LO = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_OV_HI = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_UV_LO = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_UV_HI = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_OW_LO = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_OW_HI = 8'h15;
  localparam logic [ADDR_W-1:0] ADDR_DOC_LO = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_DOC_HI = 8'h17;
  localparam logic [IDX_W-1:0] IDX_OV_LO = 3'h0;
  localparam logic [IDX_W-1:0] IDX_OV_HI = 3'h1;
  localparam logic [IDX_W-1:0] IDX_UV_LO = 3'h2;
  localparam logic [IDX_W-1:0] IDX_UV_HI = 3'h3;
  localparam logic [IDX_W-1:0] IDX_OW_LO = 3'h4;
  localparam logic [IDX_W-1:0] IDX_OW_HI = 3'h5;
  localparam logic [IDX_W-1:0] IDX_DOC_LO = 3'h6;
  localparam logic [IDX_W-1:0] IDX_DOC_HI = 3'h7;

  // ****************************************
  // Reset values, index 7 first
  // ****************************************
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RESET = {
    8'h44, 8'hA0, 8'h02, 8'h14, 8'h08, 8'h01, 8'h08, 8'h01};

  // Writable bits; all others read back as zero
  localparam logic [DATA_W-1:0] MASK_FULL = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_TIMER_HI = 8'h0F;
  localparam logic [DATA_W-1:0] MASK_OW_HI = 8'h03;
  localparam logic [DATA_W-1:0] MASK_DOC_HI = 8'h7F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CNT_HI_MSB = 1;
  localparam int CNT_HI_LSB = 0;
  localparam int UNIT_MSB = 3;
  localparam int UNIT_LSB = 2;
  localparam int THR_MSB = 6;
  localparam int THR_LSB = 4;
  localparam int OW_HI_BIT = 0;
  localparam int OW_UNIT_BIT = 1;

  typedef enum logic [1:0] {
    UNIT_US = 2'h0,
    UNIT_MS = 2'h1,
    UNIT_S = 2'h2,
    UNIT_MIN = 2'h3
  } pdt_unit_t;

  typedef enum logic [1:0] {
    OW_IDLE = 2'h1,
    OW_PULSE = 2'h2
  } pdt_ow_state_t;

  // ****************************************
  // Time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam logic [5:0] US_LAST = 6'(CYC_PER_US - 1);
  localparam logic [9:0] MS_LAST = 10'(US_PER_MS - 1);
  localparam logic [9:0] S_LAST = 10'(MS_PER_S - 1);
  localparam logic [5:0] MIN_LAST = 6'(S_PER_MIN - 1);
  localparam int NUM_UNITS = 4;

  // Discharge overcurrent threshold in millivolts
  function automatic logic [7:0] pdt_thr_mv(input logic [2:0] sel);
    unique case (sel)
      3'h0: pdt_thr_mv = 8'h04;
      3'h1: pdt_thr_mv = 8'h08;
      3'h2: pdt_thr_mv = 8'h10;
      3'h3: pdt_thr_mv = 8'h18;
      3'h4: pdt_thr_mv = 8'h20;
      3'h5: pdt_thr_mv = 8'h30;
      3'h6: pdt_thr_mv = 8'h40;
      3'h7: pdt_thr_mv = 8'h60;
    endcase
  endfunction

  function automatic logic [9:0] pdt_count10(input logic [7:0] lo,
                                             input logic [7:0] hi);
    pdt_count10 = {hi[CNT_HI_MSB:CNT_HI_LSB], lo};
  endfunction

endpackage

// ===== pdt_timer_if.sv
`timescale 1ns/10ps
interface pdt_timer_if;
  logic cond;
  logic [1:0] unitSel;
  logic [9:0] limit;
  logic [3:0] tick;
  logic expired;
  modport ctrl(output cond, output unitSel, output limit, output tick,
               input expired);
  modport timer(input cond, input unitSel, input limit, input tick,
                output expired);
endinterface

// ===== pdt_qual_timer.sv
`timescale 1ns/10ps
module pdt_qual_timer
  import pdt_pkg::*;
#(
  parameter bit STRICT = 1'b0
) (
  input wire logic clock,
  input wire logic nrst,
  pdt_timer_if.timer tif
);

  typedef struct packed {
    logic [10:0] elapsed;
    logic expired;
  } pdt_qt_t;

  localparam logic [10:0] ELAPSED_MAX = 11'h7FF;

  pdt_qt_t st_reg;
  pdt_qt_t st_next;
  logic reached;

  always_comb begin
    st_next = st_reg;
    reached = 1'b0;
    if (!tif.cond) begin
      // Interrupted condition starts over
      st_next.elapsed = 11'h000;
      st_next.expired = 1'b0;
    end else begin
      if (STRICT) begin
        reached = st_reg.elapsed > {1'b0, tif.limit};
      end else begin
        reached = st_reg.elapsed >= {1'b0, tif.limit};
      end
      if (tif.tick[tif.unitSel] && st_reg.elapsed != ELAPSED_MAX) begin
        st_next.elapsed = st_reg.elapsed + 11'h001;
      end
      st_next.expired = reached;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.expired = st_reg.expired;

  expire_clear_a: assert property (
    @(posedge clock) disable iff (!nrst)
    !tif.cond |=> !tif.expired)
    else $error("timer expiry kept after condition dropped");

  expire_cause_a: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(tif.expired) |-> $past(tif.cond) && $past(reached))
    else $error("timer expired without qualified condition");

endmodule

// ===== pdt_protection_timers.sv
`timescale 1ns/10ps
module pdt_protection_timers
  import pdt_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  input wire logic cellOverThreshold,
  input wire logic cellUnderThreshold,
  input wire logic [7:0] dischargeSenseMv,
  input wire logic hostSwitchControl,
  input wire logic chargeSwitchReq,
  input wire logic dischargeSwitchReq,
  input wire logic dischargeFaultClear,
  input wire logic loadPresentClear,
  input wire logic openWireStart,
  output logic cellOvFlag,
  output logic cellUvFlag,
  output logic dischargeOvercurrentFault,
  output logic loadPresentFlag,
  output logic chargeSwitchEnable,
  output logic dischargeSwitchEnable,
  output logic openWirePulse
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [5:0] usCnt;
    logic [9:0] msCnt;
    logic [9:0] sCnt;
    logic [5:0] minCnt;
    logic [NUM_UNITS-1:0] tick;
    pdt_ow_state_t owState;
    logic [8:0] owElapsed;
    logic [DATA_W-1:0] rdData;
    logic ovFlag;
    logic uvFlag;
    logic docFault;
    logic loadPresent;
    logic chgEn;
    logic dchEn;
    logic owPulse;
  } pdt_main_t;

  pdt_main_t st_reg;
  pdt_main_t st_next;

  pdt_timer_if ovIf();
  pdt_timer_if uvIf();
  pdt_timer_if docIf();

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic regHit(input logic [ADDR_W-1:0] a);
    regHit = (a >= ADDR_OV_LO) && (a <= ADDR_DOC_HI);
  endfunction

  function automatic logic [IDX_W-1:0] regIdx(input logic [ADDR_W-1:0] a);
    regIdx = IDX_W'(a - ADDR_OV_LO);
  endfunction

  function automatic logic [DATA_W-1:0] wrMask(input logic [IDX_W-1:0] i);
    unique case (i)
      IDX_OV_HI, IDX_UV_HI: wrMask = MASK_TIMER_HI;
      IDX_OW_HI: wrMask = MASK_OW_HI;
      IDX_DOC_HI: wrMask = MASK_DOC_HI;
      default: wrMask = MASK_FULL;
    endcase
  endfunction

  // ****************************************
  // Field views
  // ****************************************
  logic [9:0] ovLimit;
  logic [9:0] uvLimit;
  logic [9:0] docLimit;
  logic [8:0] owCount;
  logic owUnit;
  logic [2:0] docSel;
  logic docCond;

  always_comb begin
    ovLimit = pdt_count10(st_reg.regs[IDX_OV_LO],
                          st_reg.regs[IDX_OV_HI]);
    uvLimit = pdt_count10(st_reg.regs[IDX_UV_LO],
                          st_reg.regs[IDX_UV_HI]);
    docLimit = pdt_count10(st_reg.regs[IDX_DOC_LO],
                           st_reg.regs[IDX_DOC_HI]);
    owCount = {st_reg.regs[IDX_OW_HI][OW_HI_BIT],
               st_reg.regs[IDX_OW_LO]};
    owUnit = st_reg.regs[IDX_OW_HI][OW_UNIT_BIT];
    docSel = st_reg.regs[IDX_DOC_HI][THR_MSB:THR_LSB];
    docCond = dischargeSenseMv > pdt_thr_mv(docSel);
  end

  // ****************************************
  // Qualification timers
  // ****************************************
  assign ovIf.cond = cellOverThreshold;
  assign ovIf.unitSel = st_reg.regs[IDX_OV_HI][UNIT_MSB:UNIT_LSB];
  assign ovIf.limit = ovLimit;
  assign ovIf.tick = st_reg.tick;
  assign uvIf.cond = cellUnderThreshold;
  assign uvIf.unitSel = st_reg.regs[IDX_UV_HI][UNIT_MSB:UNIT_LSB];
  assign uvIf.limit = uvLimit;
  assign uvIf.tick = st_reg.tick;
  assign docIf.cond = docCond;
  assign docIf.unitSel = st_reg.regs[IDX_DOC_HI][UNIT_MSB:UNIT_LSB];
  assign docIf.limit = docLimit;
  assign docIf.tick = st_reg.tick;

  // Over and under voltage need "at least"; overcurrent needs "exceeded"
  pdt_qual_timer #(.STRICT(1'b0)) ovTimer (
    .clock(clock),
    .nrst(nrst),
    .tif(ovIf.timer)
  );

  pdt_qual_timer #(.STRICT(1'b0)) uvTimer (
    .clock(clock),
    .nrst(nrst),
    .tif(uvIf.timer)
  );

  pdt_qual_timer #(.STRICT(1'b1)) docTimer (
    .clock(clock),
    .nrst(nrst),
    .tif(docIf.timer)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic usWrap;
  logic msWrap;
  logic sWrap;
  logic minWrap;
  logic faultNow;

  always_comb begin
    st_next = st_reg;
    usWrap = st_reg.usCnt == US_LAST;
    msWrap = usWrap && st_reg.msCnt == MS_LAST;
    sWrap = msWrap && st_reg.sCnt == S_LAST;
    minWrap = sWrap && st_reg.minCnt == MIN_LAST;
    faultNow = 1'b0;

    // Unit ticks are one-cycle enables; phase is free running, so a
    // delay may run up to one unit short of count times unit
    st_next.usCnt = usWrap ? 6'h00 : st_reg.usCnt + 6'h01;
    if (usWrap) begin
      st_next.msCnt = msWrap ? 10'h000 : st_reg.msCnt + 10'h001;
    end
    if (msWrap) begin
      st_next.sCnt = sWrap ? 10'h000 : st_reg.sCnt + 10'h001;
    end
    if (sWrap) begin
      st_next.minCnt = minWrap ? 6'h00 : st_reg.minCnt + 6'h01;
    end
    st_next.tick = {minWrap, sWrap, msWrap, usWrap};

    // Reserved bits are dropped on write and read as zero
    if (regWrEn && regHit(regAddr)) begin
      st_next.regs[regIdx(regAddr)] =
        regWrData & wrMask(regIdx(regAddr));
    end
    if (regRdEn) begin
      st_next.rdData = regHit(regAddr) ? st_reg.regs[regIdx(regAddr)]
                                       : '0;
    end

    st_next.ovFlag = ovIf.expired;
    st_next.uvFlag = uvIf.expired;

    // Set wins over clear for both sticky flags
    if (dischargeFaultClear) begin
      st_next.docFault = 1'b0;
    end
    if (loadPresentClear) begin
      st_next.loadPresent = 1'b0;
    end
    if (docIf.expired) begin
      st_next.docFault = 1'b1;
      st_next.loadPresent = 1'b1;
    end
    faultNow = st_next.docFault;

    if (hostSwitchControl) begin
      // Host owns switch shutdown through its request bits
      st_next.chgEn = chargeSwitchReq;
      st_next.dchEn = dischargeSwitchReq;
    end else begin
      st_next.chgEn = chargeSwitchReq && !faultNow;
      st_next.dchEn = dischargeSwitchReq && !faultNow;
    end

    // Open-wire pulse; a zero count gives no pulse at all
    unique case (st_reg.owState)
      OW_IDLE: begin
        if (openWireStart && owCount != 9'h000) begin
          st_next.owState = OW_PULSE;
          st_next.owElapsed = 9'h000;
          st_next.owPulse = 1'b1;
        end
      end
      OW_PULSE: begin
        if (st_reg.tick[{1'b0, owUnit}]) begin
          st_next.owElapsed = st_reg.owElapsed + 9'h001;
          if (st_reg.owElapsed + 9'h001 >= owCount) begin
            st_next.owState = OW_IDLE;
            st_next.owPulse = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.regs <= REG_RESET;
      st_reg.owState <= OW_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdData = st_reg.rdData;
  assign cellOvFlag = st_reg.ovFlag;
  assign cellUvFlag = st_reg.uvFlag;
  assign dischargeOvercurrentFault = st_reg.docFault;
  assign loadPresentFlag = st_reg.loadPresent;
  assign chargeSwitchEnable = st_reg.chgEn;
  assign dischargeSwitchEnable = st_reg.dchEn;
  assign openWirePulse = st_reg.owPulse;

  // ****************************************
  // Checks
  // ****************************************
  doc_flags_a: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(dischargeOvercurrentFault) |-> loadPresentFlag)
    else $error("fault set without load present flag");

  auto_off_a: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(dischargeOvercurrentFault) && !$past(hostSwitchControl)
      |-> !chargeSwitchEnable && !dischargeSwitchEnable)
    else $error("switches left on after automatic shutdown");

  doc_cause_a: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(dischargeOvercurrentFault) |-> $past(docCond, 2))
    else $error("fault without sustained overcurrent");

  ow_start_a: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(openWirePulse) |-> $past(openWireStart) && $past(owCount) != 0)
    else $error("open-wire pulse without start");

  us_tick_a: assert property (
    @(posedge clock) disable iff (!nrst)
    st_reg.tick[0] |=> !st_reg.tick[0] [*8])
    else $error("microsecond enable too frequent");

  ow_reserved_a: assert property (
    @(posedge clock) disable iff (!nrst)
    regRdEn && regAddr == ADDR_OW_HI |=> regRdData[7:2] == 6'h00)
    else $error("reserved bits read nonzero");

  doc_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    docIf.expired |=> dischargeOvercurrentFault && loadPresentFlag)
    else $error("expiry did not set both flags");

  off_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    dischargeOvercurrentFault && !$past(hostSwitchControl)
      |-> !chargeSwitchEnable && !dischargeSwitchEnable)
    else $error("switches on during automatic shutdown");

  host_follow_a: assert property (
    @(posedge clock) disable iff (!nrst)
    hostSwitchControl |=> chargeSwitchEnable == $past(chargeSwitchReq)
      && dischargeSwitchEnable == $past(dischargeSwitchReq))
    else $error("switch enables ignore host requests");

  doc_reserved_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (st_reg.regs[IDX_DOC_HI] & ~MASK_DOC_HI) == 8'h00)
    else $error("reserved threshold bit stored");

  doc_seen_c: cover property (
    @(posedge clock) disable iff (!nrst)
    $rose(dischargeOvercurrentFault));

  ow_pulse_c: cover property (
    @(posedge clock) disable iff (!nrst)
    $fell(openWirePulse));

  ov_seen_c: cover property (
    @(posedge clock) disable iff (!nrst)
    $rose(cellOvFlag));

  uv_seen_c: cover property (
    @(posedge clock) disable iff (!nrst)
    $rose(cellUvFlag));

  host_off_c: cover property (
    @(posedge clock) disable iff (!nrst)
    dischargeOvercurrentFault && hostSwitchControl && !chargeSwitchEnable);

endmodule

// ===== pdt_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host controller model
// ****************************************
module pdt_host_model
  import pdt_pkg::*;
(
  input wire logic clock,
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic fault,
  input wire logic ctlMode,
  input wire logic swOn,
  output logic hostSwitchControl,
  output logic chargeSwitchReq,
  output logic dischargeSwitchReq
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  assign hostSwitchControl = ctlMode;

  // Host owns shutdown: it drops both switch bits once it sees the fault
  always @(posedge clock) begin
    chargeSwitchReq <= swOn && !(ctlMode && fault);
    dischargeSwitchReq <= swOn && !(ctlMode && fault);
  end

  function automatic logic [7:0] hostMask(input logic [7:0] a);
    case (a)
      ADDR_OV_HI, ADDR_UV_HI: hostMask = MASK_TIMER_HI;
      ADDR_OW_HI: hostMask = MASK_OW_HI;
      ADDR_DOC_HI: hostMask = MASK_DOC_HI;
      default: hostMask = MASK_FULL;
    endcase
  endfunction

  // Idle bus lines are inverted so stale values never look valid
  task automatic wrRaw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clock);
    #1;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wrRaw(a, d & hostMask(a));
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clock);
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    @(posedge clock);
    #1;
    d = regRdData;
  endtask
endmodule

// ===== tb_protection_delay_timers.sv
`timescale 1ns/10ps
module tb_protection_delay_timers
  import pdt_pkg::*;
;
  typedef struct {
    logic [7:0] a;
    bit w;
    logic [7:0] d;
    logic [7:0] e;
  } pdt_row_t;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, hostSwitchControl;
  logic chargeSwitchReq, dischargeSwitchReq;
  logic cellOverThreshold = 1'b0;
  logic cellUnderThreshold = 1'b0;
  logic [7:0] dischargeSenseMv = 8'h00;
  logic dischargeFaultClear = 1'b0;
  logic loadPresentClear = 1'b0;
  logic openWireStart = 1'b0;
  logic ctlMode = 1'b0;
  logic swOn = 1'b1;
  logic cellOvFlag, cellUvFlag, dischargeOvercurrentFault;
  logic loadPresentFlag, chargeSwitchEnable, dischargeSwitchEnable;
  logic openWirePulse;
  logic [6:0] outs;
  logic [7:0] got;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] thr [8] = '{8'h04, 8'h08, 8'h10, 8'h18,
                          8'h20, 8'h30, 8'h40, 8'h60};
  pdt_row_t rows [14] = '{
    '{ADDR_OV_LO, 1'b0, 8'h00, 8'h01},
    '{ADDR_OV_HI, 1'b0, 8'h00, 8'h08},
    '{ADDR_UV_LO, 1'b0, 8'h00, 8'h01},
    '{ADDR_UV_HI, 1'b0, 8'h00, 8'h08},
    '{ADDR_OW_LO, 1'b0, 8'h00, 8'h14},
    '{ADDR_OW_HI, 1'b0, 8'h00, 8'h02},
    '{ADDR_DOC_LO, 1'b0, 8'h00, 8'hA0},
    '{ADDR_DOC_HI, 1'b0, 8'h00, 8'h44},
    '{ADDR_OV_HI, 1'b1, 8'hFF, 8'h0F},
    '{ADDR_UV_HI, 1'b1, 8'hA7, 8'h07},
    '{ADDR_OW_HI, 1'b1, 8'hFF, 8'h03},
    '{ADDR_DOC_HI, 1'b1, 8'hFF, 8'h7F},
    '{ADDR_DOC_LO, 1'b1, 8'h5A, 8'h5A},
    '{8'h18, 1'b1, 8'h55, 8'h00}
  };

  always #10 clock = ~clock;

  assign outs = {cellOvFlag, cellUvFlag, dischargeOvercurrentFault,
                 loadPresentFlag, chargeSwitchEnable,
                 dischargeSwitchEnable, openWirePulse};

  pdt_protection_timers u_pdt_protection_timers (
    .clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .cellOverThreshold(cellOverThreshold),
    .cellUnderThreshold(cellUnderThreshold),
    .dischargeSenseMv(dischargeSenseMv),
    .hostSwitchControl(hostSwitchControl),
    .chargeSwitchReq(chargeSwitchReq),
    .dischargeSwitchReq(dischargeSwitchReq),
    .dischargeFaultClear(dischargeFaultClear),
    .loadPresentClear(loadPresentClear), .openWireStart(openWireStart),
    .cellOvFlag(cellOvFlag), .cellUvFlag(cellUvFlag),
    .dischargeOvercurrentFault(dischargeOvercurrentFault),
    .loadPresentFlag(loadPresentFlag),
    .chargeSwitchEnable(chargeSwitchEnable),
    .dischargeSwitchEnable(dischargeSwitchEnable),
    .openWirePulse(openWirePulse)
  );

  pdt_host_model u_pdt_host_model (
    .clock(clock), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .fault(dischargeOvercurrentFault), .ctlMode(ctlMode), .swOn(swOn),
    .hostSwitchControl(hostSwitchControl),
    .chargeSwitchReq(chargeSwitchReq),
    .dischargeSwitchReq(dischargeSwitchReq)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  function automatic logic flagOf(input int w);
    case (w)
      0: flagOf = cellOvFlag;
      1: flagOf = cellUvFlag;
      2: flagOf = dischargeOvercurrentFault;
      default: flagOf = openWirePulse;
    endcase
  endfunction

  // Output must hold off for lo cycles, then reach v within hi cycles
  task automatic qual(input string nm, input int w, input logic v,
                      input int lo, input int hi);
    int i;
    bit bad;
    bad = 1'b0;
    for (i = 0; i < lo; i++) begin
      cyc(1);
      if (flagOf(w) !== !v) bad = 1'b1;
    end
    chk({nm, " early"}, 8'h00, {7'h00, bad});
    for (i = 0; i < hi && flagOf(w) !== v; i++) cyc(1);
    chk({nm, " late"}, {7'h00, v}, {7'h00, flagOf(w)});
    if (flagOf(w) !== v) end_sim;
  endtask

  task automatic clearFault;
    dischargeSenseMv = 8'h00;
    dischargeFaultClear = 1'b1;
    loadPresentClear = 1'b1;
    // Two cycles: an expiry still pending for one cycle wins over clear
    cyc(2);
    dischargeFaultClear = 1'b0;
    loadPresentClear = 1'b0;
    cyc(2);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(4);
    chk("outputs in reset", 8'h00, {1'b0, outs});
    nrst = 1'b1;
    foreach (rows[k]) begin
      if (rows[k].w) u_pdt_host_model.wrRaw(rows[k].a, rows[k].d);
      u_pdt_host_model.rd(rows[k].a, got);
      chk($sformatf("reg %h", rows[k].a), rows[k].e, got);
    end
    $display("test registers done");

    u_pdt_host_model.wr(ADDR_OV_LO, 8'h03);
    u_pdt_host_model.wr(ADDR_OV_HI, 8'h00);
    cellOverThreshold = 1'b1;
    cyc(100);
    cellOverThreshold = 1'b0;
    cyc(5);
    cellOverThreshold = 1'b1;
    qual("ov delay", 0, 1'b1, 98, 70);
    cellOverThreshold = 1'b0;
    qual("ov fall", 0, 1'b0, 0, 4);
    $display("test overvoltage done");

    u_pdt_host_model.wr(ADDR_UV_LO, 8'h00);
    u_pdt_host_model.wr(ADDR_UV_HI, 8'h01);
    cellUnderThreshold = 1'b1;
    qual("uv delay", 1, 1'b1, 12740, 100);
    cellUnderThreshold = 1'b0;
    qual("uv fall", 1, 1'b0, 0, 4);
    $display("test undervoltage done");

    u_pdt_host_model.wr(ADDR_DOC_LO, 8'h00);
    for (int s = 0; s < 8; s++) begin
      u_pdt_host_model.wr(ADDR_DOC_HI, {1'b0, 3'(s), 4'h0});
      dischargeSenseMv = thr[s];
      cyc(60);
      chk("fault at threshold", 8'h00, {7'h00, flagOf(2)});
      dischargeSenseMv = thr[s] + 8'h01;
      qual("fault over threshold", 2, 1'b1, 0, 60);
      clearFault;
    end
    $display("test thresholds done");

    u_pdt_host_model.wr(ADDR_DOC_LO, 8'h02);
    u_pdt_host_model.wr(ADDR_DOC_HI, 8'h40);
    chk("switches on", 8'h03, {6'h00, outs[2:1]});
    dischargeSenseMv = 8'h21;
    qual("doc delay", 2, 1'b1, 98, 70);
    chk("load flag", 8'h01, {7'h00, loadPresentFlag});
    chk("auto off", 8'h00, {6'h00, outs[2:1]});
    clearFault;
    chk("switches back", 8'h03, {6'h00, outs[2:1]});
    ctlMode = 1'b1;
    cyc(3);
    dischargeSenseMv = 8'h21;
    qual("doc host", 2, 1'b1, 98, 70);
    chk("host keeps", 8'h03, {6'h00, outs[2:1]});
    cyc(3);
    chk("host off", 8'h00, {6'h00, outs[2:1]});
    dischargeFaultClear = 1'b1;
    loadPresentClear = 1'b1;
    cyc(1);
    chk("set wins", 8'h03, {6'h00, outs[4:3]});
    clearFault;
    chk("flags cleared", 8'h00, {6'h00, outs[4:3]});
    ctlMode = 1'b0;
    $display("test overcurrent done");

    u_pdt_host_model.wr(ADDR_OW_LO, 8'h03);
    u_pdt_host_model.wr(ADDR_OW_HI, 8'h00);
    openWireStart = 1'b1;
    cyc(1);
    openWireStart = 1'b0;
    chk("pulse start", 8'h01, {7'h00, openWirePulse});
    qual("pulse width", 3, 1'b0, 96, 70);
    $display("test open wire done");

    u_pdt_host_model.wr(ADDR_DOC_LO, 8'h55);
    nrst = 1'b0;
    cyc(2);
    chk("outputs in reset", 8'h00, {1'b0, outs});
    nrst = 1'b1;
    u_pdt_host_model.rd(ADDR_DOC_LO, got);
    chk("delay after reset", 8'hA0, got);
    $display("test reset done");
    end_sim;
  end
endmodule
